// *** rtl/prtr_pkg.sv ***
// shared constants and carrier types for the program store table-read block
package prtr_pkg;

  // store geometry
  localparam int          ADDR_W       = 15;
  localparam int          DATA_W       = 16;
  localparam int          DEPTH        = 32768;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;

  // data-memory destination layout
  localparam int          SECTOR_W     = 3;
  localparam logic [2:0]  SECTOR_ZERO  = 3'h0;

  // timing, in instruction cycles
  localparam int          TABLE_CYCLES = 2;
  localparam logic [0:0]  LAST_TBL_CYC = 1'(TABLE_CYCLES - 1);

  // serial programming frame: op bit, address bits, then data bits
  localparam logic [4:0]  ICP_ADDR_END = 5'h0F;
  localparam logic [4:0]  ICP_LAST_BIT = 5'h1F;

  // four non-overlapping phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_T1,
    PH_T2,
    PH_T3,
    PH_T4
  } prtr_phase_e;

  typedef enum logic {
    TR_IDLE,
    TR_BUSY
  } prtr_tr_state_e;

  // table pointer as the core holds it
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } prtr_tbl_ptr_s;

  // table read request from the core
  typedef struct packed {
    logic                req;
    logic                extended;
    logic [SECTOR_W-1:0] sector;
    logic [7:0]          offset;
  } prtr_tbl_req_s;

  // write of the low table byte into data memory
  typedef struct packed {
    logic                wr_en;
    logic [SECTOR_W-1:0] sector;
    logic [7:0]          offset;
    logic [7:0]          data;
  } prtr_dest_wr_s;

endpackage

// *** rtl/prtr_icp_serial.sv ***
// serial in-circuit programming engine for the program store
`timescale 1ns/1ps
module prtr_icp_serial (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  // programming pins
  input  wire logic                        prog_mode,
  input  wire logic                        prog_serial_clock,
  input  wire logic                        prog_serial_data_in,
  output logic                             prog_serial_data_out,
  output logic                             prog_serial_data_oe_n,
  // store access
  output logic [prtr_pkg::ADDR_W-1:0]      mem_addr,
  output logic [prtr_pkg::DATA_W-1:0]      mem_wr_data,
  output logic                             mem_wr_en,
  input  wire logic [prtr_pkg::DATA_W-1:0] mem_rd_data
);

  logic [2:0]                  sync_clk;
  logic [1:0]                  sync_dat;
  logic [1:0]                  sync_mode;
  logic [4:0]                  bit_cnt;
  logic                        op_write;
  logic [prtr_pkg::DATA_W-1:0] shift;
  logic [4:0]                  next_bit_cnt;
  logic                        next_op_write;
  logic [prtr_pkg::DATA_W-1:0] next_shift;
  logic [prtr_pkg::ADDR_W-1:0] next_mem_addr;
  logic                        next_wr_en;
  logic                        next_dout;
  logic                        next_oe_n;
  logic                        clk_rise;
  logic                        upload_pend;
  logic                        next_upload_pend;

  // only the second and third stages are looked at; stage one feeds stage two alone
  assign clk_rise = sync_clk[1] & ~sync_clk[2];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_clk  <= 3'h0;
      sync_dat  <= 2'h0;
      sync_mode <= 2'h0;
    end else begin
      sync_clk  <= {sync_clk[1:0], prog_serial_clock};
      sync_dat  <= {sync_dat[0], prog_serial_data_in};
      sync_mode <= {sync_mode[0], prog_mode};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_op_write = op_write;
    next_shift    = shift;
    next_mem_addr = mem_addr;
    next_wr_en    = 1'b0;
    next_dout     = prog_serial_data_out;
    next_oe_n     = prog_serial_data_oe_n;
    next_upload_pend = 1'b0;
    if (!sync_mode[1]) begin
      // leaving programming mode abandons any half frame
      next_bit_cnt = 5'h00;
      next_oe_n    = 1'b1;
    end else if (upload_pend) begin
      // the address became whole on the previous clock, so the store now shows the right word
      next_shift = {mem_rd_data[prtr_pkg::DATA_W-2:0], 1'b0};
      next_dout  = mem_rd_data[prtr_pkg::DATA_W-1];
      next_oe_n  = 1'b0;
    end else if (clk_rise) begin
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'h00) begin
        next_op_write = sync_dat[1];
      end else if (bit_cnt <= prtr_pkg::ICP_ADDR_END) begin
        next_mem_addr = {mem_addr[prtr_pkg::ADDR_W-2:0], sync_dat[1]};
      end else begin
        next_shift = {shift[prtr_pkg::DATA_W-2:0], sync_dat[1]};
      end
      if (!op_write && bit_cnt == prtr_pkg::ICP_ADDR_END) begin
        // upload: the line turns round one clock later, once the last address bit is in
        next_upload_pend = 1'b1;
      end else if (!op_write && bit_cnt > prtr_pkg::ICP_ADDR_END) begin
        next_dout  = shift[prtr_pkg::DATA_W-1];
        next_shift = {shift[prtr_pkg::DATA_W-2:0], 1'b0};
      end
      if (bit_cnt == prtr_pkg::ICP_LAST_BIT) begin
        next_bit_cnt = 5'h00;
        next_oe_n    = 1'b1;
        next_wr_en   = op_write;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt               <= 5'h00;
      op_write              <= 1'b0;
      shift                 <= 16'h0000;
      mem_addr              <= 15'h0000;
      mem_wr_en             <= 1'b0;
      prog_serial_data_out  <= 1'b0;
      prog_serial_data_oe_n <= 1'b1;
      upload_pend           <= 1'b0;
    end else begin
      bit_cnt               <= next_bit_cnt;
      op_write              <= next_op_write;
      shift                 <= next_shift;
      mem_addr              <= next_mem_addr;
      mem_wr_en             <= next_wr_en;
      prog_serial_data_out  <= next_dout;
      prog_serial_data_oe_n <= next_oe_n;
      upload_pend           <= next_upload_pend;
    end
  end

  assign mem_wr_data = shift;

  ////////////////////////////////////////////////////////////////////////////
  AST_ICP_DRIVE_ONLY_READ: assert property (@(posedge core_clk) disable iff (!reset_n)
    !prog_serial_data_oe_n |-> !op_write && sync_mode[1])
    else $error("programming line driven outside an upload");

  AST_ICP_WRITE_PULSE: assert property (@(posedge core_clk) disable iff (!reset_n)
    mem_wr_en |=> !mem_wr_en && bit_cnt == 5'h00)
    else $error("programming write not a single pulse at frame end");

endmodule

// *** rtl/prtr_table_read.sv ***
// program store with instruction fetch, table read path and serial programming
`timescale 1ns/1ps
// How it works
// - program store holds 32K words of 16 bits, fetch and table data alike
// - after reset the first fetch comes from word address zero
// - table pointer low byte and bits 6:0 of the high byte form the word address; high bit 7 is ignored
// - table read sends low byte to destination, high byte to holding latch
// - short form reaches sector 0 only; extended form reaches any sector
// - holding latch can be written and read by software
// - every accepted table read occupies two instruction cycles; a refused short-form read occupies none
// - programming moves serial data both ways on one line, external clock
// - instruction cycle is four phases; counter advances entering the first
module prtr_table_read (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  // program counter control from the core
  input  wire logic                        pc_load_en,
  input  wire logic [prtr_pkg::ADDR_W-1:0] pc_load_addr,
  // instruction fetch
  output logic                             cycle_start,
  output logic [prtr_pkg::ADDR_W-1:0]      fetch_addr,
  output logic [prtr_pkg::DATA_W-1:0]      instr_word,
  output logic                             instr_valid,
  // table read
  input  wire prtr_pkg::prtr_tbl_ptr_s     tbl_ptr,
  input  wire prtr_pkg::prtr_tbl_req_s     tbl_req,
  output prtr_pkg::prtr_dest_wr_s          dest_wr,
  output logic                             tbl_busy,
  output logic                             tbl_done,
  output logic                             tbl_refused,
  // high-byte holding latch
  input  wire logic                        table_high_byte_latch_wr_en,
  input  wire logic [7:0]                  table_high_byte_latch_wr_data,
  output logic [7:0]                       table_high_byte_latch,
  // serial programming pins
  input  wire logic                        prog_mode,
  input  wire logic                        prog_serial_clock,
  input  wire logic                        prog_serial_data_in,
  output logic                             prog_serial_data_out,
  output logic                             prog_serial_data_oe_n
);

  logic [prtr_pkg::DATA_W-1:0] mem [prtr_pkg::DEPTH];
  logic [prtr_pkg::ADDR_W-1:0] icp_addr;
  logic [prtr_pkg::DATA_W-1:0] icp_wr_data;
  logic                        icp_wr_en;

  prtr_pkg::prtr_phase_e       phase;
  prtr_pkg::prtr_phase_e       next_phase;
  prtr_pkg::prtr_tr_state_e    tr_state;
  prtr_pkg::prtr_tr_state_e    next_tr_state;
  logic [0:0]                  tr_cyc;
  logic [0:0]                  next_tr_cyc;
  logic [prtr_pkg::ADDR_W-1:0] tr_addr;
  logic [prtr_pkg::ADDR_W-1:0] next_tr_addr;
  prtr_pkg::prtr_dest_wr_s     tr_dest;
  prtr_pkg::prtr_dest_wr_s     next_tr_dest;
  prtr_pkg::prtr_dest_wr_s     next_dest_wr;
  logic [prtr_pkg::ADDR_W-1:0] next_pc;
  logic [prtr_pkg::DATA_W-1:0] next_instr_word;
  logic                        next_instr_valid;
  logic                        next_cycle_start;
  logic                        next_done;
  logic                        next_refused;
  logic [7:0]                  next_table_high_byte_latch;
  logic                        take;
  logic                        finish;
  logic                        first_fetch;

  ////////////////////////////////////////////////////////////////////////////
  // program store; only the programming engine writes it, no reset on the array
  always_ff @(posedge core_clk) begin
    if (icp_wr_en) begin
      mem[icp_addr] <= icp_wr_data;
    end
  end

  prtr_icp_serial u_icp (
    .core_clk              (core_clk),
    .reset_n               (reset_n),
    .prog_mode             (prog_mode),
    .prog_serial_clock     (prog_serial_clock),
    .prog_serial_data_in   (prog_serial_data_in),
    .prog_serial_data_out  (prog_serial_data_out),
    .prog_serial_data_oe_n (prog_serial_data_oe_n),
    .mem_addr              (icp_addr),
    .mem_wr_data           (icp_wr_data),
    .mem_wr_en             (icp_wr_en),
    .mem_rd_data           (mem[icp_addr])
  );

  ////////////////////////////////////////////////////////////////////////////
  // requests are taken only in T1 so a read always spans two whole cycles
  assign take   = tbl_req.req && phase == prtr_pkg::PH_T1 && tr_state == prtr_pkg::TR_IDLE;
  assign finish = tr_state == prtr_pkg::TR_BUSY && phase == prtr_pkg::PH_T4
                  && tr_cyc == prtr_pkg::LAST_TBL_CYC;

  always_comb begin
    next_phase       = prtr_pkg::PH_T1;
    next_pc          = fetch_addr;
    next_instr_word  = instr_word;
    next_instr_valid = 1'b0;
    case (phase)
      prtr_pkg::PH_T1: begin
        next_phase = prtr_pkg::PH_T2;
        // the second cycle of a table read fetches nothing new
        if (!(tr_state == prtr_pkg::TR_BUSY && tr_cyc == prtr_pkg::LAST_TBL_CYC)) begin
          next_instr_word  = mem[fetch_addr];
          next_instr_valid = 1'b1;
        end
      end
      prtr_pkg::PH_T2: next_phase = prtr_pkg::PH_T3;
      prtr_pkg::PH_T3: next_phase = prtr_pkg::PH_T4;
      prtr_pkg::PH_T4: begin
        next_phase = prtr_pkg::PH_T1;
        if (pc_load_en) begin
          next_pc = pc_load_addr;
        end else if (!(tr_state == prtr_pkg::TR_BUSY && tr_cyc != prtr_pkg::LAST_TBL_CYC)) begin
          next_pc = fetch_addr + 15'h0001;
        end
      end
      default: next_phase = prtr_pkg::PH_T1;
    endcase
    next_cycle_start = next_phase == prtr_pkg::PH_T1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase       <= prtr_pkg::PH_T1;
      fetch_addr  <= prtr_pkg::RESET_VECTOR;
      instr_word  <= 16'h0000;
      instr_valid <= 1'b0;
      cycle_start <= 1'b1;
    end else begin
      phase       <= next_phase;
      fetch_addr  <= next_pc;
      instr_word  <= next_instr_word;
      instr_valid <= next_instr_valid;
      cycle_start <= next_cycle_start;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_tr_state = tr_state;
    next_tr_cyc   = tr_cyc;
    next_tr_addr  = tr_addr;
    next_tr_dest  = tr_dest;
    next_dest_wr  = '0;
    next_done     = 1'b0;
    next_refused  = 1'b0;
    next_table_high_byte_latch     = table_high_byte_latch;
    // software write first so a finishing read overrides it in the same cycle
    if (table_high_byte_latch_wr_en) begin
      next_table_high_byte_latch = table_high_byte_latch_wr_data;
    end
    case (tr_state)
      prtr_pkg::TR_IDLE: begin
        if (take && !tbl_req.extended && tbl_req.sector != prtr_pkg::SECTOR_ZERO) begin
          next_refused = 1'b1;
        end else if (take) begin
          next_tr_state       = prtr_pkg::TR_BUSY;
          next_tr_cyc         = 1'b0;
          next_tr_addr        = {tbl_ptr.high[6:0], tbl_ptr.low};
          next_tr_dest.sector = tbl_req.sector;
          next_tr_dest.offset = tbl_req.offset;
        end
      end
      prtr_pkg::TR_BUSY: begin
        if (finish) begin
          next_tr_state      = prtr_pkg::TR_IDLE;
          next_dest_wr       = tr_dest;
          next_dest_wr.wr_en = 1'b1;
          next_dest_wr.data  = mem[tr_addr][7:0];
          next_table_high_byte_latch          = mem[tr_addr][15:8];
          next_done          = 1'b1;
        end else if (phase == prtr_pkg::PH_T4) begin
          next_tr_cyc = tr_cyc + 1'b1;
        end
      end
      default: next_tr_state = prtr_pkg::TR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tr_state              <= prtr_pkg::TR_IDLE;
      tr_cyc                <= 1'b0;
      tr_addr               <= 15'h0000;
      tr_dest               <= '0;
      dest_wr               <= '0;
      tbl_busy              <= 1'b0;
      tbl_done              <= 1'b0;
      tbl_refused           <= 1'b0;
      table_high_byte_latch <= 8'h00;
    end else begin
      tr_state              <= next_tr_state;
      tr_cyc                <= next_tr_cyc;
      tr_addr               <= next_tr_addr;
      tr_dest               <= next_tr_dest;
      dest_wr               <= next_dest_wr;
      tbl_busy              <= next_tr_state == prtr_pkg::TR_BUSY;
      tbl_done              <= next_done;
      tbl_refused           <= next_refused;
      table_high_byte_latch <= next_table_high_byte_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper: stays high until the first fetch after reset has been delivered
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_fetch <= 1'b1;
    end else if (instr_valid) begin
      first_fetch <= 1'b0;
    end
  end

  AST_RESET_VECTOR: assert property (@(posedge core_clk) disable iff (!reset_n)
    // the store is unknown until loaded, so the fetch address is what is checked here
    instr_valid && first_fetch |-> fetch_addr == prtr_pkg::RESET_VECTOR
                                   && $past(fetch_addr) == prtr_pkg::RESET_VECTOR)
    else $error("first fetch after reset not from the reset vector");

  AST_PHASE_ORDER: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase == prtr_pkg::PH_T1 |=> phase == prtr_pkg::PH_T2 ##1 phase == prtr_pkg::PH_T3
                                 ##1 phase == prtr_pkg::PH_T4 ##1 cycle_start)
    else $error("instruction phases out of order");

  AST_PC_ADVANCE: assert property (@(posedge core_clk) disable iff (!reset_n)
    phase == prtr_pkg::PH_T4 && !pc_load_en && tr_state == prtr_pkg::TR_IDLE
    |=> fetch_addr == $past(fetch_addr) + 15'h0001 && phase == prtr_pkg::PH_T1)
    else $error("program counter did not advance entering T1");

  AST_TWO_CYCLES: assert property (@(posedge core_clk) disable iff (!reset_n)
    take && (tbl_req.extended || tbl_req.sector == prtr_pkg::SECTOR_ZERO)
    |=> !tbl_done [*7] ##1 tbl_done)
    else $error("table read did not finish in two instruction cycles");

  AST_SHORT_SECTOR: assert property (@(posedge core_clk) disable iff (!reset_n)
    take && !tbl_req.extended && tbl_req.sector != prtr_pkg::SECTOR_ZERO
    |=> tbl_refused && !tbl_busy)
    else $error("short table read outside sector 0 not refused");

  AST_TABLE_DATA: assert property (@(posedge core_clk) disable iff (!reset_n)
    finish |=> dest_wr.wr_en && {table_high_byte_latch, dest_wr.data} == $past(mem[tr_addr])
               && dest_wr.offset == $past(tr_dest.offset))
    else $error("table word split wrongly");

  AST_SW_WRITE: assert property (@(posedge core_clk) disable iff (!reset_n)
    table_high_byte_latch_wr_en && !finish |=> table_high_byte_latch == $past(table_high_byte_latch_wr_data))
    else $error("software write to holding latch lost");

  AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(table_high_byte_latch) |-> tbl_done || $past(table_high_byte_latch_wr_en))
    else $error("holding latch changed without a cause");

endmodule

// *** tb/prtr_prog_model.sv ***
// serial programmer model that loads and reads back the program store
`timescale 1ns/1ps
module prtr_prog_model (
  // clock
  input  wire logic core_clk,
  // programming pins
  output logic      prog_mode,
  output logic      prog_serial_clock,
  output logic      drive_en,
  output logic      drive_val,
  input  wire logic pin_level
);
  initial begin
    prog_mode = 1'b0;
    prog_serial_clock = 1'b0;
    drive_en = 1'b0;
    drive_val = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic set_mode(input logic m);
    prog_mode = m;
    tick(8);
  endtask

  // six core clocks per level leaves margin over the device's synchroniser delay
  task automatic frame(input logic wr, input logic [14:0] a, input logic [15:0] d,
                       output logic [15:0] q);
    logic [31:0] bits;
    bits = {wr, a, d};
    q = 16'h0000;
    for (int i = 0; i < 32; i++) begin
      drive_en = wr || i < 16;
      drive_val = bits[31-i];
      tick(6);
      prog_serial_clock = 1'b1;
      tick(6);
      if (!wr && i >= 15 && i <= 30) begin
        q[30-i] = pin_level;
      end
      prog_serial_clock = 1'b0;
    end
    drive_en = 1'b0;
    tick(8);
  endtask
endmodule

// *** tb/prtr_table_read_test.sv ***
// self-checking bench for the program store table-read block
`timescale 1ns/1ps
`define CHECK_EQ(got, want, msg) \
  begin \
    compares++; \
    if ((got) !== (want)) begin \
      failures++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end

module prtr_table_read_test;
  ////////////////////////////////////////////////////////////////////////////////
  logic                        core_clk = 1'b0;
  logic                        reset_n = 1'b0;
  logic                        pc_load_en = 1'b0;
  logic [14:0]                 pc_load_addr = 15'h0000;
  logic                        cycle_start;
  logic [14:0]                 fetch_addr;
  logic [15:0]                 instr_word;
  logic                        instr_valid;
  prtr_pkg::prtr_tbl_ptr_s     tbl_ptr = '0;
  prtr_pkg::prtr_tbl_req_s     tbl_req = '0;
  prtr_pkg::prtr_dest_wr_s     dest_wr;
  logic                        tbl_busy;
  logic                        tbl_done;
  logic                        tbl_refused;
  logic                        table_high_byte_latch_wr_en = 1'b0;
  logic [7:0]                  table_high_byte_latch_wr_data = 8'h00;
  logic [7:0]                  table_high_byte_latch;
  logic                        prog_mode;
  logic                        prog_serial_clock;
  logic                        prog_serial_data_out;
  logic                        prog_serial_data_oe_n;
  logic                        drive_en;
  logic                        drive_val;
  logic                        pin_level;
  logic                        last_level = 1'b0;
  logic [15:0]                 rd;
  logic [15:0]                 img [logic [14:0]];
  logic [14:0]                 addrs [$];
  int                          failures = 0;
  int                          compares = 0;
  int                          cyc = 0;

  always #2.5 core_clk = ~core_clk;

  // nobody drives the data line: it drifts, never holds its last value
  always_comb begin
    if (!prog_serial_data_oe_n) pin_level = prog_serial_data_out;
    else if (drive_en) pin_level = drive_val;
    else pin_level = ~last_level;
  end
  always @(posedge core_clk) last_level <= pin_level;

  prtr_table_read dut (
    .core_clk(core_clk), .reset_n(reset_n), .pc_load_en(pc_load_en),
    .pc_load_addr(pc_load_addr), .cycle_start(cycle_start), .fetch_addr(fetch_addr),
    .instr_word(instr_word), .instr_valid(instr_valid), .tbl_ptr(tbl_ptr),
    .tbl_req(tbl_req), .dest_wr(dest_wr), .tbl_busy(tbl_busy), .tbl_done(tbl_done),
    .tbl_refused(tbl_refused), .table_high_byte_latch_wr_en(table_high_byte_latch_wr_en), .table_high_byte_latch_wr_data(table_high_byte_latch_wr_data),
    .table_high_byte_latch(table_high_byte_latch), .prog_mode(prog_mode),
    .prog_serial_clock(prog_serial_clock), .prog_serial_data_in(pin_level),
    .prog_serial_data_out(prog_serial_data_out),
    .prog_serial_data_oe_n(prog_serial_data_oe_n));

  prtr_prog_model u_prog (
    .core_clk(core_clk), .prog_mode(prog_mode), .prog_serial_clock(prog_serial_clock),
    .drive_en(drive_en), .drive_val(drive_val), .pin_level(pin_level));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      complete_run();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // destination write expected from a table word: low byte goes out, high byte to the latch
  function automatic prtr_pkg::prtr_dest_wr_s exp_dest(input logic [2:0]  sec,
                                                       input logic [7:0]  off,
                                                       input logic [15:0] w);
    return '{1'b1, sec, off, w[7:0]};
  endfunction

  // one caller only, so no interleaved read can clobber the latch
  task automatic tbl_read(input logic ext, input logic [2:0] sec, input logic [14:0] a,
                          input logic hib, input logic collide);
    logic [7:0]              off;
    logic [7:0]              old;
    prtr_pkg::prtr_dest_wr_s exp_wr;
    off = 8'($urandom);
    for (int i = 0; i < 12 && !(cycle_start === 1'b1 && tbl_busy === 1'b0); i++) tick(1);
    old = table_high_byte_latch;
    tbl_ptr = '{{hib, a[14:8]}, a[7:0]};
    tbl_req = '{1'b1, ext, sec, off};
    tick(1);
    tbl_req.req = 1'b0;
    if (!ext && sec != 3'h0) begin
      `CHECK_EQ(tbl_refused, 1'b1, "short form outside sector 0 not refused");
      `CHECK_EQ(tbl_busy, 1'b0, "refused read went busy");
      repeat (8) begin
        tick(1);
        `CHECK_EQ(dest_wr.wr_en, 1'b0, "refused read wrote data");
      end
      `CHECK_EQ(table_high_byte_latch, old, "latch moved on refused read");
    end else begin
      repeat (6) begin
        `CHECK_EQ(tbl_done, 1'b0, "read finished early");
        `CHECK_EQ(tbl_busy, 1'b1, "not busy during read");
        tick(1);
      end
      `CHECK_EQ(tbl_done, 1'b0, "read finished early");
      if (collide) begin
        table_high_byte_latch_wr_en = 1'b1;
        table_high_byte_latch_wr_data = ~img[a][15:8];
      end
      tick(1);
      table_high_byte_latch_wr_en = 1'b0;
      exp_wr = exp_dest(sec, off, img[a]);
      `CHECK_EQ(tbl_done, 1'b1, "read not done after two cycles");
      `CHECK_EQ(tbl_busy, 1'b0, "still busy after done");
      `CHECK_EQ(dest_wr, exp_wr, "wrong low byte or destination");
      `CHECK_EQ(table_high_byte_latch, img[a][15:8], "wrong high byte");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [14:0] tgt;
    logic [7:0]  d;
    void'($urandom(98));
    tick(4);
    reset_n = 1'b1;
    for (int i = 0; i < 16; i++) addrs.push_back(15'(i));
    addrs.push_back(15'h7F05);
    addrs.push_back(15'h7F06);
    addrs.push_back(15'h7FFF);
    repeat (6) addrs.push_back(15'($urandom));
    foreach (addrs[i]) img[addrs[i]] = 16'($urandom);
    img[15'h7F05] = 16'h000F;
    img[15'h7F06] = 16'h001A;
    u_prog.set_mode(1'b1);
    foreach (addrs[i]) u_prog.frame(1'b1, addrs[i], img[addrs[i]], rd);
    u_prog.frame(1'b0, 15'h7FFF, 16'h0000, rd);
    `CHECK_EQ(rd, img[15'h7FFF], "serial read of top word");
    u_prog.frame(1'b0, addrs[21], 16'h0000, rd);
    `CHECK_EQ(rd, img[addrs[21]], "serial read of random word");
    u_prog.set_mode(1'b0);
    $display("test serial load done");

    reset_n = 1'b0;
    tick(4);
    `CHECK_EQ(fetch_addr, 15'h0000, "pc not zero in reset");
    `CHECK_EQ(prog_serial_data_oe_n, 1'b1, "data line driven in reset");
    reset_n = 1'b1;
    tick(1);
    `CHECK_EQ(instr_valid, 1'b1, "no first fetch");
    `CHECK_EQ(instr_word, img[15'h0000], "first fetch not from zero");
    `CHECK_EQ(cycle_start, 1'b0, "cycle start outside first phase");
    for (int k = 1; k < 4; k++) begin
      tick(3);
      `CHECK_EQ(cycle_start, 1'b1, "instruction cycle not four clocks");
      `CHECK_EQ(fetch_addr, 15'(k), "pc did not advance");
      tick(1);
      `CHECK_EQ(instr_word, img[15'(k)], "wrong fetched word");
    end
    tick(2);
    tgt = 15'($urandom_range(4, 15));
    pc_load_en = 1'b1;
    pc_load_addr = tgt;
    tick(1);
    pc_load_en = 1'b0;
    `CHECK_EQ(fetch_addr, tgt, "pc load ignored");
    tick(1);
    `CHECK_EQ(instr_word, img[tgt], "wrong word after pc load");
    $display("test fetch done");

    d = 8'($urandom);
    table_high_byte_latch_wr_en = 1'b1;
    table_high_byte_latch_wr_data = d;
    tick(1);
    table_high_byte_latch_wr_en = 1'b0;
    `CHECK_EQ(table_high_byte_latch, d, "latch write lost");
    tick(10);
    `CHECK_EQ(table_high_byte_latch, d, "latch did not hold");
    $display("test latch done");

    tbl_read(1'b0, 3'h0, 15'h7F06, 1'b0, 1'b0);
    tbl_read(1'b0, 3'h0, 15'h7F05, 1'b1, 1'b0);
    tbl_read(1'b1, 3'h5, 15'h7FFF, 1'b0, 1'b0);
    tbl_read(1'b0, 3'h3, 15'h0002, 1'b0, 1'b0);
    tbl_read(1'b1, 3'h0, addrs[20], 1'b0, 1'b1);
    repeat (24) begin
      tbl_read(1'($urandom), 3'($urandom), addrs[$urandom_range(0, addrs.size() - 1)],
               1'($urandom), 1'($urandom));
    end
    $display("test table read done");
    complete_run();
  end
endmodule
